// ---- rtl/lha_key_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Inactivity timer: counts while armed, restarts on a key press
module lha_key_timer #(
  parameter int unsigned TIMEOUT_CYC = 1200000000,
  parameter int unsigned CNT_W       = 31
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic arm_i,
  input  wire logic restart_i,
  output logic      expire_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expire;
  } lha_tmr_state_type;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

  lha_tmr_state_type st_ff;
  lha_tmr_state_type nxt_st;

  // Next count and expiry pulse
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.expire = 1'b0;
    if (!arm_i || restart_i) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == LAST) begin
      nxt_st.cnt    = '0;
      nxt_st.expire = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
  end

  // State register, frozen by enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else if (en_i) begin
      st_ff <= nxt_st;
    end
  end

  assign expire_o = st_ff.expire;

endmodule

`default_nettype wire

// ---- rtl/lha_logic_io.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "lha_regs.svh"

// How it works
// - Selector 0 keeps the pin free of any alarm indication.
// - Selector 1 signals on the unit alarm only.
// - Selector 2 signals on low oxygen only.
// - Selector 4 signals on high impedance or calibration due only.
// - Selector 3 signals on unit alarm or low oxygen.
// - Selector 5 signals on unit alarm or calibration due; default without sequencer.
// - Selector 6 signals on low oxygen or calibration due.
// - Selector 7 signals on unit alarm, low oxygen or calibration due.
// - Selector 8 is handshake; calibration due starts a cycle; default with sequencer.
// - Selector 9 is handshake; calibration due does not start a cycle.
// - Selectors 0 to 7 drive the pin one way as alarm only.
// - Selector is parameter 40, written as 1 to 10 for modes 0 to 9.
// - Pin level reported as parameter 41, 0 false, 1 true.
// - First increment or decrement press switches test point to calibration gas.
// - Later presses raise or lower the calibration gas setting.
// - One minute without key presses returns test point to process gas.
// - Critical alarm flags this and all later readings bad, status out of service.
module lha_logic_io #(
  parameter int unsigned IDLE_CYCLES = `LHA_IDLE_CYC,
  parameter int unsigned IDLE_CNT_W  = 31
) (
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic                       CLK_EN_I,
  input  wire logic                       SEQ_FITTED_I,
  input  wire logic                       PARAM_WR_I,
  input  wire logic [7:0]                 PARAM_NUM_I,
  input  wire logic [3:0]                 PARAM_DATA_I,
  input  wire lha_pkg::lha_alarm_src_type ALARM_SRC_I,
  input  wire logic                       CAL_INIT_I,
  input  wire logic                       CRIT_ALARM_I,
  input  wire lha_pkg::lha_keys_type      KEYS_I,
  input  wire logic                       IO_PIN_I,
  output logic                            IO_PIN_O,
  output logic                            IO_PIN_OE_O,
  output logic [3:0]                      MODE_PARAM_O,
  output logic                            PIN_STATE_O,
  output logic                            HANDSHAKE_MODE_O,
  output logic                            SEQ_ANSWER_O,
  output logic                            PARAM_ACK_O,
  output logic                            PARAM_ERR_O,
  output logic                            READY_O,
  output logic                            TP_CAL_GAS_O,
  output logic                            CAL_GAS_UP_O,
  output logic                            CAL_GAS_DN_O,
  output logic                            READING_BAD_O,
  output logic                            OUT_OF_SERVICE_O
);

  // ****************************************************************
  // State
  // ****************************************************************

  typedef struct packed {
    lha_pkg::lha_init_type init;
    lha_pkg::lha_mode_type mode;
    logic [1:0]            strap_sync;
    logic [1:0]            pin_sync;
    logic [1:0]            inc_sync;
    logic [1:0]            dec_sync;
    logic                  inc_prev;
    logic                  dec_prev;
    logic                  pin_out;
    logic                  pin_oe;
    logic                  pin_state;
    logic                  seq_answer;
    logic                  param_ack;
    logic                  param_err;
    logic                  tp_cal;
    logic                  gas_up;
    logic                  gas_dn;
    logic                  bad;
    logic                  ready;
    logic                  hs_mode;
    logic [3:0]            mode_param;
  } lha_state_type;

  lha_state_type st_ff;
  lha_state_type nxt_st;

  logic idle_expire;
  logic key_press;

  // ****************************************************************
  // Decoding
  // ****************************************************************

  // Enabled-source mask of a selector; empty in handshake modes
  function automatic logic [2:0] alarm_mask(input lha_pkg::lha_mode_type m);
    logic [2:0] msk;
    msk = 3'h0;
    if (m <= lha_pkg::lha_mode_type'(`LHA_MODE_LAST_ALARM)) begin
      msk = m[2:0];
    end
    return msk;
  endfunction

  // True for the two handshake selectors
  function automatic logic is_handshake(input lha_pkg::lha_mode_type m);
    return (m == lha_pkg::LHA_M_HS_AUTO) || (m == lha_pkg::LHA_M_HS_MAN);
  endfunction

  // Parameter value 1..10 is legal
  function automatic logic param_ok(input logic [3:0] v);
    return (v >= `LHA_PARAM_MIN) && (v <= `LHA_PARAM_MAX);
  endfunction

  // Key press from synchronised pins
  assign key_press = (st_ff.inc_sync[1] & ~st_ff.inc_prev) |
                     (st_ff.dec_sync[1] & ~st_ff.dec_prev);

  // ****************************************************************
  // Inactivity timer
  // ****************************************************************

  lha_key_timer #(
    .TIMEOUT_CYC (IDLE_CYCLES),
    .CNT_W       (IDLE_CNT_W)
  ) u_idle (
    .clk_i     (SYS_CLK_I),
    .rst_n_i   (RST_N_I),
    .en_i      (CLK_EN_I),
    .arm_i     (st_ff.tp_cal),
    .restart_i (key_press),
    .expire_o  (idle_expire)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    logic [2:0] msk;
    logic       alarm_hit;
    logic       hs_req;
    logic       inc_edge;
    logic       dec_edge;
    msk       = 3'h0;
    alarm_hit = 1'b0;
    hs_req    = 1'b0;
    inc_edge  = 1'b0;
    dec_edge  = 1'b0;
    nxt_st    = st_ff;

    // Pin synchronisers, two stages each
    nxt_st.strap_sync = {st_ff.strap_sync[0], SEQ_FITTED_I};
    nxt_st.pin_sync   = {st_ff.pin_sync[0], IO_PIN_I};
    nxt_st.inc_sync   = {st_ff.inc_sync[0], KEYS_I.inc};
    nxt_st.dec_sync   = {st_ff.dec_sync[0], KEYS_I.dec};
    nxt_st.inc_prev   = st_ff.inc_sync[1];
    nxt_st.dec_prev   = st_ff.dec_sync[1];
    inc_edge          = st_ff.inc_sync[1] & ~st_ff.inc_prev;
    dec_edge          = st_ff.dec_sync[1] & ~st_ff.dec_prev;

    // One-cycle answers default low
    nxt_st.param_ack = 1'b0;
    nxt_st.param_err = 1'b0;
    nxt_st.gas_up    = 1'b0;
    nxt_st.gas_dn    = 1'b0;

    // Start-up: settle the strap, then load the factory selector
    unique case (st_ff.init)
      lha_pkg::LHA_INIT_SYNC0: begin
        nxt_st.init = lha_pkg::LHA_INIT_SYNC1;
      end
      lha_pkg::LHA_INIT_SYNC1: begin
        nxt_st.init = lha_pkg::LHA_INIT_LOAD;
      end
      lha_pkg::LHA_INIT_LOAD: begin
        nxt_st.init = lha_pkg::LHA_INIT_RUN;
        if (st_ff.strap_sync[1]) begin
          nxt_st.mode = lha_pkg::lha_mode_type'(`LHA_MODE_DEF_SEQ);
        end else begin
          nxt_st.mode = lha_pkg::lha_mode_type'(`LHA_MODE_DEF_ALONE);
        end
      end
      lha_pkg::LHA_INIT_RUN: begin
        if (PARAM_WR_I && PARAM_NUM_I == `LHA_PNUM_MODE) begin
          if (param_ok(PARAM_DATA_I)) begin
            nxt_st.mode      = lha_pkg::lha_mode_type'(PARAM_DATA_I - 4'h1);
            nxt_st.param_ack = 1'b1;
          end else begin
            nxt_st.param_err = 1'b1;
          end
        end else if (PARAM_WR_I) begin
          // Pin state is read only; other numbers are not ours
          nxt_st.param_err = 1'b1;
        end
      end
    endcase

    // enabled sources of the present selector
    msk = alarm_mask(st_ff.mode);
    alarm_hit = (msk[`LHA_MSK_UNIT] & ALARM_SRC_I.unit) |
                (msk[`LHA_MSK_LOW]  & ALARM_SRC_I.low_o2) |
                (msk[`LHA_MSK_CAL]  & (ALARM_SRC_I.high_imp | ALARM_SRC_I.cal_rec));

    // only automatic mode lets calibration due request a cycle
    hs_req = CAL_INIT_I | ((st_ff.mode == lha_pkg::LHA_M_HS_AUTO) & ALARM_SRC_I.cal_rec);

    if (st_ff.init != lha_pkg::LHA_INIT_RUN) begin
      // Pin released until the selector is known
      nxt_st.pin_oe  = 1'b0;
      nxt_st.pin_out = 1'b0;
    end else if (is_handshake(st_ff.mode)) begin
      // Handshake: drive only while requesting, else listen
      nxt_st.pin_oe  = hs_req;
      nxt_st.pin_out = hs_req;
    end else begin
      // alarm modes always drive, one way
      nxt_st.pin_oe  = 1'b1;
      nxt_st.pin_out = alarm_hit;
    end

    // Sequencer answer seen while the pin is released
    nxt_st.seq_answer = is_handshake(st_ff.mode) & ~st_ff.pin_oe & st_ff.pin_sync[1];

    // present pin level, driven or sensed
    nxt_st.pin_state = st_ff.pin_oe ? st_ff.pin_out : st_ff.pin_sync[1];

    // first press selects calibration gas, later presses adjust
    if (inc_edge || dec_edge) begin
      if (!st_ff.tp_cal) begin
        nxt_st.tp_cal = 1'b1;
      end else if (inc_edge) begin
        nxt_st.gas_up = 1'b1;
      end else begin
        nxt_st.gas_dn = 1'b1;
      end
    end else if (idle_expire) begin
      nxt_st.tp_cal = 1'b0;
    end

    if (CRIT_ALARM_I) begin
      nxt_st.bad = 1'b1;
    end

    // Registered copies of decoded status, so outputs come from flops
    nxt_st.ready      = (nxt_st.init == lha_pkg::LHA_INIT_RUN);
    nxt_st.hs_mode    = nxt_st.mode[3];
    nxt_st.mode_param = 4'(nxt_st.mode) + 4'h1;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // State register, frozen while the clock enable is low
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_ff      <= '0;
      st_ff.init <= lha_pkg::LHA_INIT_SYNC0;
      st_ff.mode <= lha_pkg::LHA_M_OFF;
      st_ff.mode_param <= `LHA_MODE_PARAM_RST;
    end else if (CLK_EN_I) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Pin and status
  assign IO_PIN_O         = st_ff.pin_out;
  assign IO_PIN_OE_O      = st_ff.pin_oe;
  assign PIN_STATE_O      = st_ff.pin_state;
  assign SEQ_ANSWER_O     = st_ff.seq_answer;
  assign READY_O          = st_ff.ready;
  assign HANDSHAKE_MODE_O = st_ff.hs_mode;

  assign MODE_PARAM_O = st_ff.mode_param;

  // Parameter write answers
  assign PARAM_ACK_O = st_ff.param_ack;
  assign PARAM_ERR_O = st_ff.param_err;

  // Test point
  assign TP_CAL_GAS_O = st_ff.tp_cal;
  assign CAL_GAS_UP_O = st_ff.gas_up;
  assign CAL_GAS_DN_O = st_ff.gas_dn;

  assign READING_BAD_O    = st_ff.bad;
  assign OUT_OF_SERVICE_O = st_ff.bad;

endmodule

`default_nettype wire

// ---- rtl/lha_pkg.sv ----
package lha_pkg;

  // Pin function selector
  typedef enum logic [3:0] {
    LHA_M_OFF      = 4'h0,
    LHA_M_UNIT     = 4'h1,
    LHA_M_LOW      = 4'h2,
    LHA_M_UNIT_LOW = 4'h3,
    LHA_M_CAL      = 4'h4,
    LHA_M_UNIT_CAL = 4'h5,
    LHA_M_LOW_CAL  = 4'h6,
    LHA_M_ALL      = 4'h7,
    LHA_M_HS_AUTO  = 4'h8,
    LHA_M_HS_MAN   = 4'h9
  } lha_mode_type;

  // Start-up sequence
  typedef enum logic [1:0] {
    LHA_INIT_SYNC0 = 2'h0,
    LHA_INIT_SYNC1 = 2'h1,
    LHA_INIT_LOAD  = 2'h2,
    LHA_INIT_RUN   = 2'h3
  } lha_init_type;

  // Alarm sources
  typedef struct packed {
    logic cal_rec;
    logic high_imp;
    logic low_o2;
    logic unit;
  } lha_alarm_src_type;

  // Key pin pair
  typedef struct packed {
    logic inc;
    logic dec;
  } lha_keys_type;

endpackage

// ---- rtl/lha_regs.svh ----
`ifndef LHA_REGS_SVH
`define LHA_REGS_SVH

// ****************************************************************
// Mode selector values
// ****************************************************************
`define LHA_MODE_W          4
`define LHA_MODE_DEF_ALONE  4'h5
`define LHA_MODE_DEF_SEQ    4'h8
`define LHA_MODE_LAST_ALARM 4'h7
`define LHA_PARAM_MIN       4'h1
`define LHA_PARAM_MAX       4'ha
`define LHA_MODE_PARAM_RST  4'h1

// ****************************************************************
// Network parameter numbers
// ****************************************************************
`define LHA_PNUM_MODE       8'h28
`define LHA_PNUM_STATE      8'h29

// ****************************************************************
// Alarm mask field positions
// ****************************************************************
`define LHA_MSK_UNIT        0
`define LHA_MSK_LOW         1
`define LHA_MSK_CAL         2

// ****************************************************************
// Timing
// ****************************************************************
`define LHA_CLK_HZ          20000000
`define LHA_IDLE_TIME_S     60
`define LHA_IDLE_CYC        (`LHA_IDLE_TIME_S * `LHA_CLK_HZ)

`endif

// ---- verification/lha_logic_io_chk.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Port checker
// ****************************************************************
module lha_logic_io_chk (
  input wire logic                       SYS_CLK_I,
  input wire logic                       RST_N_I,
  input wire logic                       CLK_EN_I,
  input wire logic                       SEQ_FITTED_I,
  input wire logic                       PARAM_WR_I,
  input wire logic [7:0]                 PARAM_NUM_I,
  input wire logic [3:0]                 PARAM_DATA_I,
  input wire lha_pkg::lha_alarm_src_type ALARM_SRC_I,
  input wire logic                       CAL_INIT_I,
  input wire logic                       CRIT_ALARM_I,
  input wire logic                       IO_PIN_O,
  input wire logic                       IO_PIN_OE_O,
  input wire logic [3:0]                 MODE_PARAM_O,
  input wire logic                       PIN_STATE_O,
  input wire logic                       HANDSHAKE_MODE_O,
  input wire logic                       PARAM_ACK_O,
  input wire logic                       PARAM_ERR_O,
  input wire logic                       READY_O,
  input wire logic                       TP_CAL_GAS_O,
  input wire logic                       CAL_GAS_UP_O,
  input wire logic                       CAL_GAS_DN_O,
  input wire logic                       READING_BAD_O,
  input wire logic                       OUT_OF_SERVICE_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Alarm level for a selector value and source set
  function automatic logic alarm_lvl(input logic [3:0] p, input lha_pkg::lha_alarm_src_type s);
    logic [3:0] m;
    m = p - 4'h1;
    return (m[0] & s.unit) | (m[1] & s.low_o2) | (m[2] & (s.high_imp | s.cal_rec));
  endfunction

  // Accepted selector writes and refused writes to other numbers
  sequence s_wr_ok;
    CLK_EN_I && READY_O && PARAM_WR_I && PARAM_NUM_I == 8'h28 &&
      PARAM_DATA_I inside {[4'h1:4'ha]};
  endsequence
  sequence s_wr_bad;
    CLK_EN_I && READY_O && PARAM_WR_I && PARAM_NUM_I != 8'h28;
  endsequence

  a_write_accept: assert property (s_wr_ok |=> PARAM_ACK_O && MODE_PARAM_O == $past(PARAM_DATA_I))
    else $error("selector write not taken");
  a_write_refuse: assert property (s_wr_bad |=> PARAM_ERR_O && !PARAM_ACK_O && $stable(MODE_PARAM_O))
    else $error("bad write not refused");
  a_alarm_follow: assert property ($past(READY_O, 2) && $past(CLK_EN_I) && !$past(HANDSHAKE_MODE_O)
    |-> IO_PIN_OE_O && IO_PIN_O == alarm_lvl($past(MODE_PARAM_O), $past(ALARM_SRC_I)))
    else $error("alarm pin wrong");
  a_hs_drive: assert property ($past(READY_O, 2) && $past(CLK_EN_I) && $past(HANDSHAKE_MODE_O)
    |-> IO_PIN_O == IO_PIN_OE_O && IO_PIN_OE_O == ($past(CAL_INIT_I) ||
      ($past(MODE_PARAM_O) == 4'h9 && $past(ALARM_SRC_I.cal_rec))))
    else $error("handshake request wrong");
  a_state_report: assert property ($past(READY_O, 3) && $past(CLK_EN_I) &&
    !$past(HANDSHAKE_MODE_O, 2) && !$past(HANDSHAKE_MODE_O) |-> PIN_STATE_O == $past(IO_PIN_O))
    else $error("pin state report wrong");
  a_crit_latch: assert property (CLK_EN_I && (CRIT_ALARM_I || READING_BAD_O)
    |=> READING_BAD_O && OUT_OF_SERVICE_O)
    else $error("critical flags not held");
  a_first_press: assert property ($rose(TP_CAL_GAS_O) |-> !CAL_GAS_UP_O && !CAL_GAS_DN_O)
    else $error("first press stepped gas");
  a_step_needs_cal: assert property (CAL_GAS_UP_O || CAL_GAS_DN_O |-> $past(TP_CAL_GAS_O))
    else $error("step without cal gas view");
  a_start_default: assert property ($rose(READY_O)
    |-> MODE_PARAM_O == (SEQ_FITTED_I ? 4'h9 : 4'h6))
    else $error("start-up selector wrong");
endmodule

bind lha_logic_io lha_logic_io_chk lha_logic_io_chk_i (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CLK_EN_I(CLK_EN_I), .SEQ_FITTED_I(SEQ_FITTED_I),
  .PARAM_WR_I(PARAM_WR_I), .PARAM_NUM_I(PARAM_NUM_I), .PARAM_DATA_I(PARAM_DATA_I),
  .ALARM_SRC_I(ALARM_SRC_I), .CAL_INIT_I(CAL_INIT_I), .CRIT_ALARM_I(CRIT_ALARM_I),
  .IO_PIN_O(IO_PIN_O), .IO_PIN_OE_O(IO_PIN_OE_O), .MODE_PARAM_O(MODE_PARAM_O),
  .PIN_STATE_O(PIN_STATE_O), .HANDSHAKE_MODE_O(HANDSHAKE_MODE_O), .PARAM_ACK_O(PARAM_ACK_O),
  .PARAM_ERR_O(PARAM_ERR_O), .READY_O(READY_O), .TP_CAL_GAS_O(TP_CAL_GAS_O),
  .CAL_GAS_UP_O(CAL_GAS_UP_O), .CAL_GAS_DN_O(CAL_GAS_DN_O), .READING_BAD_O(READING_BAD_O),
  .OUT_OF_SERVICE_O(OUT_OF_SERVICE_O)
);

`default_nettype wire

// ---- verification/lha_logic_io_test.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Bench
// ****************************************************************
module lha_logic_io_test;
  logic                       clk;
  logic                       rst_n;
  logic                       seq_fit;
  logic                       clk_en;
  logic                       wr;
  logic [7:0]                 num;
  logic [3:0]                 data;
  lha_pkg::lha_alarm_src_type src;
  logic                       cal_init;
  logic                       crit;
  lha_pkg::lha_keys_type      keys;
  logic                       answer;
  logic                       pin_i;
  logic [3:0]                 mode_p;
  logic                       pin_o, pin_oe, pst, hs, seq_ans, ack, err, ready;
  logic                       tp, up, dn, bad, oos;
  int                         fail_count = 0;
  int                         compares = 0;
  int                         cycles = 0;

  // Block under test and far side
  lha_logic_io #(.IDLE_CYCLES(20), .IDLE_CNT_W(5)) lha_logic_io_i (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(clk_en), .SEQ_FITTED_I(seq_fit),
    .PARAM_WR_I(wr), .PARAM_NUM_I(num), .PARAM_DATA_I(data), .ALARM_SRC_I(src),
    .CAL_INIT_I(cal_init), .CRIT_ALARM_I(crit), .KEYS_I(keys), .IO_PIN_I(pin_i),
    .IO_PIN_O(pin_o), .IO_PIN_OE_O(pin_oe), .MODE_PARAM_O(mode_p), .PIN_STATE_O(pst),
    .HANDSHAKE_MODE_O(hs), .SEQ_ANSWER_O(seq_ans), .PARAM_ACK_O(ack), .PARAM_ERR_O(err),
    .READY_O(ready), .TP_CAL_GAS_O(tp), .CAL_GAS_UP_O(up), .CAL_GAS_DN_O(dn),
    .READING_BAD_O(bad), .OUT_OF_SERVICE_O(oos));
  lha_seq_model lha_seq_model_i (.drive_i(pin_o), .drive_en_i(pin_oe), .answer_i(answer),
    .line_o(pin_i));

  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  // Compare and tally
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Reset, then wait for start-up
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    seq_fit <= s;
    tick(12);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) tick(1);
    check(ready, 1'b1);
    tick(1);
  endtask

  // One parameter write, answer sampled in the cycle after it
  task automatic wr_par(input logic [7:0] n, input logic [3:0] d, output logic a, output logic e);
    @(posedge clk);
    wr <= 1'b1;
    num <= n;
    data <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    a = ack;
    e = err;
  endtask

  task automatic t_alarm();
    logic a, e, x;
    for (int m = 0; m < 8; m++) begin
      wr_par(8'h28, 4'(m + 1), a, e);
      check(a, 1'b1);
      for (int s = 0; s < 16; s++) begin
        @(posedge clk);
        src <= lha_pkg::lha_alarm_src_type'(4'(s));
        tick(3);
        x = (m[0] & s[0]) | (m[1] & s[1]) | (m[2] & (s[2] | s[3]));
        check(pin_o, x);
        check(pin_oe, 1'b1);
        check(pst, x);
      end
    end
    $display("alarm modes done");
  endtask

  task automatic t_refuse();
    logic [11:0] bad_wr [3] = '{12'h280, 12'h28b, 12'h292};
    logic        a, e;
    for (int i = 0; i < 3; i++) begin
      wr_par(bad_wr[i][11:4], bad_wr[i][3:0], a, e);
      check({a, e}, 2'h1);
      check(mode_p, 4'h8);
    end
    $display("refused writes done");
  endtask

  // Key press, step pulses gathered over the response
  task automatic press(input logic inc, output logic u, output logic d);
    u = 1'b0;
    d = 1'b0;
    @(posedge clk);
    keys <= lha_pkg::lha_keys_type'({inc, ~inc});
    repeat (6) begin
      tick(1);
      u |= up;
      d |= dn;
    end
    keys <= '0;
    tick(6);
  endtask

  task automatic t_keys();
    logic u, d;
    check(tp, 1'b0);
    press(1'b1, u, d);
    check({tp, u, d}, 3'h4);
    press(1'b1, u, d);
    check({tp, u, d}, 3'h6);
    press(1'b0, u, d);
    check({tp, u, d}, 3'h5);
    tick(4);
    check(tp, 1'b1);
    tick(12);
    check(tp, 1'b0);
    $display("keys done");
  endtask

  task automatic t_crit();
    check({bad, oos}, 2'h0);
    @(posedge clk);
    clk_en <= 1'b0;
    crit <= 1'b1;
    tick(4);
    check({bad, oos}, 2'h0);
    clk_en <= 1'b1;
    @(posedge clk);
    crit <= 1'b0;
    tick(6);
    check({bad, oos}, 2'h3);
    $display("critical done");
  endtask

  task automatic t_hs();
    logic a, e;
    do_reset(1'b1);
    check({hs, mode_p}, 5'h19);
    @(posedge clk);
    src <= lha_pkg::lha_alarm_src_type'(4'h8);
    tick(3);
    check({pin_oe, pin_o}, 2'h3);
    @(posedge clk);
    src <= '0;
    answer <= 1'b1;
    tick(6);
    check({pin_oe, seq_ans}, 2'h1);
    answer <= 1'b0;
    wr_par(8'h28, 4'ha, a, e);
    check(a, 1'b1);
    @(posedge clk);
    src <= lha_pkg::lha_alarm_src_type'(4'h8);
    tick(3);
    check(pin_oe, 1'b0);
    @(posedge clk);
    cal_init <= 1'b1;
    tick(3);
    check(pin_oe, 1'b1);
    $display("handshake done");
  endtask

  // Verdict
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    seq_fit = 1'b0;
    clk_en = 1'b1;
    wr = 1'b0;
    num = 8'h00;
    data = 4'h0;
    src = '0;
    cal_init = 1'b0;
    crit = 1'b0;
    keys = '0;
    answer = 1'b0;
    do_reset(1'b0);
    check(mode_p, 4'h6);
    t_alarm();
    t_refuse();
    t_keys();
    t_crit();
    t_hs();
    wrap_up();
  end
endmodule

`default_nettype wire

// ---- verification/lha_seq_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Far-side calibration sequencer
// ****************************************************************
module lha_seq_model (
  input  wire logic drive_i,
  input  wire logic drive_en_i,
  input  wire logic answer_i,
  output logic      line_o
);
  // handshake line only
  // Sequencer pulls the released line high to answer, its load keeps it low otherwise
  assign line_o = drive_en_i ? drive_i : answer_i;
endmodule

`default_nettype wire
